/* pei_pkg.sv */
// Purpose: constants shared by the event status and interrupt control block
// Assumes: 16-bit management registers reached over a plain register port
// Notes:   offsets are register indices on the management port
package pei_pkg;
    localparam logic [4:0]  ADDR_CONTROL    = 5'h11;
    localparam logic [4:0]  ADDR_STATUS     = 5'h12;
    localparam logic [4:0]  ADDR_CTRL_TWO   = 5'h1C;
    localparam int          NUM_EVENTS      = 8;
    localparam int          STAT_LSB        = 8;
    localparam int          CTL_TEST_BIT    = 2;
    localparam int          CTL_GLOBAL_BIT  = 1;
    localparam int          CTL_OE_BIT      = 0;
    localparam int          CTL_DUPSEL_BIT  = 3;
    localparam int          SEL_HI_BIT      = 8;
    localparam int          SEL_LO_BIT      = 7;
    localparam logic [15:0] RESET_STATUS    = 16'h0000;
    localparam logic [3:0]  RESET_CONTROL   = 4'h0;
    localparam logic [1:0]  RESET_SEL       = 2'h0;
    localparam logic [15:0] READ_ZERO       = 16'h0000;
endpackage

/* pei_evt_if.sv */
// Purpose: carries mapped events and the read clear into the event latch
// Assumes: single clock domain
// Notes:   event bit order matches status bits 15 down to 8
`timescale 1ns/1ps
`default_nettype none
interface pei_evt_if;
    logic [7:0] evt;
    logic       clear;
    logic [7:0] pending;
    modport src (output evt, output clear, input pending);
    modport dst (input evt, input clear, output pending);
endinterface
`default_nettype wire

/* pei_evt_latch.sv */
// Purpose: sticky clear-on-read event flags
// Assumes: clear is a one-cycle pulse from a status read
// Notes:   a new event in the clear cycle survives
`timescale 1ns/1ps
`default_nettype none
module pei_evt_latch
    import pei_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST,
    pei_evt_if.dst    ev
);
    logic [7:0] flag_reg;
    logic [7:0] flag_next;

    always_comb begin
        flag_next = (ev.clear ? 8'h00 : flag_reg) | ev.evt;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag_reg <= RESET_STATUS[15:8];
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign ev.pending = flag_reg;
endmodule
`default_nettype wire

/* pei_top.sv */
// Purpose: event status, per-event enables and interrupt control for the PHY
// Assumes: event inputs are one-cycle pulses synchronous to CLK
// Notes:   read data valid the cycle after the read strobe
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - status bit sets on any event since the last status read
// - enabled event raises the interrupt
// - interrupt also needs the control register to permit it
// - status flags set regardless of their enables
// - bit 15 quality event, resets 0, cleared by read returning it
// - bit 14 energy detect change, resets 0, clear on read
// - bit 13 link status change, resets 0, clear on read
// - bit 12 speed change, resets 0, clear on read
// - bit 11 duplex change when control bit 3 is 0
// - bit 10 autonegotiation complete, resets 0, clear on read
// - select bits both 0: bit 9 false carrier counter half full
// - any select bit set: bit 9 either counter half full
// - select bits both 0: bit 8 receive error counter half full
// - any select bit set: bit 8 control frame received
// - enables for quality, energy, link at bits 7,6,5, reset 0
// - enables for speed, duplex, autoneg, bit9, bit8 at bits 4..0
// - global enable permits event interrupts; clear blocks them
// - output enable makes shared pin an interrupt output
// - test bit forces interrupt while set
module pei_top
    import pei_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [4:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [15:0] RDATA,
    input  wire logic        QUALITY_EVT,
    input  wire logic        ENERGY_EVT,
    input  wire logic        LINK_EVT,
    input  wire logic        RATE_EVT,
    input  wire logic        DUPLEX_EVT,
    input  wire logic        AUTONEG_EVT,
    input  wire logic        FALSE_CARRIER_HALF,
    input  wire logic        RX_ERROR_HALF,
    input  wire logic        CONTROL_FRAME_EVT,
    input  wire logic        PIN_IN,
    output var  logic        PIN_OUT,
    output var  logic        PIN_OE_N,
    output var  logic        POWERDOWN_REQ
);
    pei_evt_if evif ();

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  enable_reg;
    logic [7:0]  enable_next;
    logic [3:0]  control_reg;
    logic [3:0]  control_next;
    logic [1:0]  sel_reg;
    logic [1:0]  sel_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        irq_n_reg;
    logic        irq_n_next;
    logic        oe_n_reg;
    logic        oe_n_next;
    logic        pd_reg;
    logic        pd_next;
    logic        alt_mode;
    logic        dup_sel;
    logic [7:0]  evt_vec;
    logic        event_irq;

    // ****************************************
    // decode and gating
    // ****************************************
    logic        wr_status;
    logic        wr_control;
    logic        wr_sel;
    logic        rd_status;
    logic        rd_control;
    logic        rd_sel;
    wire  logic [7:0] armed;

    assign alt_mode = |sel_reg;
    assign dup_sel  = control_reg[CTL_DUPSEL_BIT];

    // ****************************************
    // event mapping
    // ****************************************
    always_comb begin
        evt_vec[7] = QUALITY_EVT;
        evt_vec[6] = ENERGY_EVT;
        evt_vec[5] = LINK_EVT;
        evt_vec[4] = RATE_EVT;
        evt_vec[3] = DUPLEX_EVT & ~dup_sel;
        evt_vec[2] = AUTONEG_EVT;
        if (alt_mode) begin
            evt_vec[1] = FALSE_CARRIER_HALF | RX_ERROR_HALF;
            evt_vec[0] = CONTROL_FRAME_EVT;
        end else begin
            evt_vec[1] = FALSE_CARRIER_HALF;
            evt_vec[0] = RX_ERROR_HALF;
        end
    end

    assign evif.evt      = evt_vec;
    // reading the status register clears every flag it returned
    assign evif.clear    = rd_status;

    pei_evt_latch u_latch (
        .CLK (CLK),
        .RST (RST),
        .ev  (evif)
    );

    // ****************************************
    // address decode
    // ****************************************
    // one strobe per register; unmapped indices fall through as no-ops
    always_comb begin
        wr_status  = 1'b0;
        wr_control = 1'b0;
        wr_sel     = 1'b0;
        rd_status  = 1'b0;
        rd_control = 1'b0;
        rd_sel     = 1'b0;
        case (ADDR)
            ADDR_STATUS: begin
                wr_status = WR;
                rd_status = RD;
            end
            ADDR_CONTROL: begin
                wr_control = WR;
                rd_control = RD;
            end
            ADDR_CTRL_TWO: begin
                wr_sel = WR;
                rd_sel = RD;
            end
            default: begin
                wr_status = 1'b0;
                rd_status = 1'b0;
            end
        endcase
    end

    // ****************************************
    // per-event enable gating
    // ****************************************
    for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_arm
        assign armed[g] = evif.pending[g] & enable_reg[g];
    end

    // ****************************************
    // event enables
    // ****************************************
    always_comb begin
        enable_next = enable_reg;
        if (wr_status) begin
            // flag half of the word is read-only, only enables take the write
            enable_next = WDATA[7:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enable_reg <= RESET_STATUS[7:0];
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ****************************************
    // interrupt control
    // ****************************************
    always_comb begin
        control_next = control_reg;
        if (wr_control) begin
            control_next = WDATA[3:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            control_reg <= RESET_CONTROL;
        end else begin
            control_reg <= control_next;
        end
    end

    // ****************************************
    // counter select
    // ****************************************
    // mode is applied when an event lands, not when the flag is read
    always_comb begin
        sel_next = sel_reg;
        if (wr_sel) begin
            sel_next = WDATA[SEL_HI_BIT:SEL_LO_BIT];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sel_reg <= RESET_SEL;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rdata_next = READ_ZERO;
        if (rd_status) begin
            // flags go out as they stand before this read clears them
            rdata_next = {evif.pending, enable_reg};
        end else if (rd_control) begin
            rdata_next = {12'h000, control_reg};
        end else if (rd_sel) begin
            rdata_next = {7'h00, sel_reg, 7'h00};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    // test bit bypasses the global enable so the pin wiring can be proven
    always_comb begin
        event_irq  = (|armed) & control_reg[CTL_GLOBAL_BIT];
        irq_n_next = ~(event_irq | control_reg[CTL_TEST_BIT]);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= irq_n_next;
        end
    end

    // ****************************************
    // pin direction
    // ****************************************
    always_comb begin
        oe_n_next = ~control_reg[CTL_OE_BIT];
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= oe_n_next;
        end
    end

    // ****************************************
    // power-down request
    // ****************************************
    always_comb begin
        // pin acts as power-down input only while not driven
        pd_next = ~control_reg[CTL_OE_BIT] & ~PIN_IN;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_reg <= 1'b0;
        end else begin
            pd_reg <= pd_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign RDATA         = rdata_reg;
    assign PIN_OUT       = irq_n_reg;
    assign PIN_OE_N      = oe_n_reg;
    assign POWERDOWN_REQ = pd_reg;
endmodule
`default_nettype wire

/* pei_assertions.sv */
// Purpose: port checks for pei_top
// Assumes: shadows follow the writes seen on the port
// Notes:   pin checks allow one register stage
`timescale 1ns/1ps
`default_nettype none
module pei_assertions
    import pei_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [4:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        QUALITY_EVT,
    input wire logic        LINK_EVT,
    input wire logic        PIN_IN,
    input wire logic        PIN_OUT,
    input wire logic        PIN_OE_N,
    input wire logic        POWERDOWN_REQ
);
    // ********
    // shadows
    // ********
    logic [7:0] en_reg;
    logic [3:0] ctl_reg;
    logic       idle;
    logic       st_rd;
    assign idle = !WR && !RD;
    assign st_rd = RD && ADDR == ADDR_STATUS;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_reg  <= 8'h00;
            ctl_reg <= 4'h0;
        end else if (WR && ADDR == ADDR_STATUS) begin
            en_reg <= WDATA[7:0];
        end else if (WR && ADDR == ADDR_CONTROL) begin
            ctl_reg <= WDATA[3:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not idle");
    a_enable_read: assert property (st_rd |=> RDATA[7:0] == en_reg)
        else $error("enable readback wrong");
    // events excluded at both edges, else set wins over the clear
    a_clear_read: assert property ((st_rd && !QUALITY_EVT)[*2] |=> !RDATA[15])
        else $error("flag not cleared");
    a_irq_raise: assert property (
        LINK_EVT && en_reg[5] && ctl_reg[CTL_GLOBAL_BIT] && idle ##1 idle[*2] |=> !PIN_OUT)
        else $error("irq not raised");
    a_global_off: assert property ((!ctl_reg[1] && !ctl_reg[2])[*3] |-> PIN_OUT)
        else $error("irq without global enable");
    a_test_force: assert property (ctl_reg[CTL_TEST_BIT][*3] |-> !PIN_OUT)
        else $error("test irq not forced");
    a_oe_follow: assert property ($stable(ctl_reg[0])[*2] |-> PIN_OE_N == !ctl_reg[0])
        else $error("pin enable wrong");
    a_pd_input: assert property ((!ctl_reg[0])[*3] |-> POWERDOWN_REQ == !$past(PIN_IN))
        else $error("power down request wrong");
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench for pei_top
// Assumes: read data one cycle after the strobe
// Notes:   pins are checked here and by the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb
    import pei_pkg::*;
;
    // ******
    // bench
    // ******
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        pin_in = 1'b1;
    logic [8:0]  evt = 9'h000;
    logic [15:0] rdata;
    logic [15:0] exp_q[$];
    logic [2:0]  pin_q[$];
    logic        look = 1'b0;
    logic        pin_out;
    logic        pin_oe_n;
    logic        pd_req;
    int          n_fail = 0;
    int          comparisons = 0;
    pei_top i_pei_top (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .QUALITY_EVT(evt[8]), .ENERGY_EVT(evt[7]), .LINK_EVT(evt[6]),
        .RATE_EVT(evt[5]), .DUPLEX_EVT(evt[4]), .AUTONEG_EVT(evt[3]),
        .FALSE_CARRIER_HALF(evt[2]), .RX_ERROR_HALF(evt[1]), .CONTROL_FRAME_EVT(evt[0]),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .POWERDOWN_REQ(pd_req));
    initial forever #12.5 clk = ~clk;
    task automatic stop_test();
        if (exp_q.size() != 0 || pin_q.size() != 0) n_fail++;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // bit 9/8 sources follow the mode set before the event
    function automatic logic [7:0] flags(input logic [8:0] e, input logic [1:0] s, input logic d);
        flags = {e[8:5], e[4] & !d, e[3], (|s) ? |e[2:1] : e[2], (|s) ? e[0] : e[1]};
    endfunction
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back(d);
    endtask
    task automatic pulse(input logic [8:0] e);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        evt <= e;
        @(posedge clk);
        evt <= 9'h000;
        repeat (2) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] e);
        comparisons++;
        if (rdata !== e) begin
            n_fail++;
            $display("[ERR] rdata exp %h seen %h", e, rdata);
        end
    endtask
    task automatic chk_pin(input logic [2:0] e);
        comparisons++;
        if ({pin_out, pin_oe_n, pd_req} !== e) begin
            n_fail++;
            $display("[ERR] pins exp %b seen %b", e, {pin_out, pin_oe_n, pd_req});
        end
    endtask
    // pins are settled long before; look marks the edge at which they are judged
    task automatic pins(input logic [2:0] e);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        look <= 1'b1;
        pin_q.push_back(e);
        @(posedge clk);
        look <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) chk(exp_q.pop_front());
        if (look && pin_q.size() > 0) chk_pin(pin_q.pop_front());
        rd_d <= rd;
    end
    initial begin
        logic [8:0]  e;
        logic [15:0] w;
        logic [7:0]  f;
        logic [3:0]  c;
        logic [1:0]  s;
        logic [2:0]  x;
        logic        p;
        void'($urandom(89723));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, ADDR_STATUS, RESET_STATUS);
        bus(1'b0, ADDR_CONTROL, 16'h0000);
        bus(1'b1, 5'h05, 16'hFFFF);
        bus(1'b0, 5'h05, READ_ZERO);
        pins(3'h6);
        for (int i = 0; i < 16; i++) begin
            s = 2'(i);
            c = 4'($urandom);
            w = 16'($urandom);
            e = 9'($urandom);
            p = 1'($urandom);
            pin_in <= p;
            bus(1'b1, ADDR_CTRL_TWO, {7'h00, s, 7'h00});
            bus(1'b1, ADDR_CONTROL, {12'h000, c});
            bus(1'b1, ADDR_STATUS, w);
            pulse(e);
            f = flags(e, s, c[CTL_DUPSEL_BIT]);
            x[2] = ~((|(f & w[7:0]) & c[CTL_GLOBAL_BIT]) | c[CTL_TEST_BIT]);
            x[1:0] = {~c[CTL_OE_BIT], ~c[CTL_OE_BIT] & ~p};
            pins(x);
            bus(1'b0, ADDR_STATUS, {f, w[7:0]});
            bus(1'b0, ADDR_STATUS, {8'h00, w[7:0]});
            bus(1'b0, ADDR_CONTROL, {12'h000, c});
            pins({~c[CTL_TEST_BIT], x[1:0]});
        end
        pulse(9'h000);
        stop_test();
    end
endmodule
bind pei_top pei_assertions i_pei_assertions (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .QUALITY_EVT(QUALITY_EVT),
    .LINK_EVT(LINK_EVT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
    .POWERDOWN_REQ(POWERDOWN_REQ));
`default_nettype wire
